// ---- core/crs_pkg.sv ----
// Constants shared by the completion return stream block
package crs_pkg;
	// Register byte offsets
	localparam logic [7:0] CRS_CTRL_OFS   = 8'h00;
	localparam logic [7:0] CRS_STAT_OFS   = 8'h04;
	localparam logic [7:0] CRS_CPLCNT_OFS = 8'h08;
	localparam logic [7:0] CRS_NULCNT_OFS = 8'h0C;
	localparam logic [7:0] CRS_LOG0_OFS   = 8'h10;
	localparam logic [7:0] CRS_LOG4_OFS   = 8'h20;
	// Control fields and reset value
	localparam int         CRS_CTRL_EN    = 0;
	localparam int         CRS_CTRL_ADDR  = 1;
	localparam int         CRS_CTRL_EP    = 2;
	localparam logic [2:0] CRS_CTRL_RST   = 3'h5;
	// Status fields
	localparam int         CRS_ST_INPKT   = 0;
	localparam int         CRS_ST_LOGV    = 1;
	localparam int         CRS_ST_ABORT   = 2;
	localparam int         CRS_ST_MISUSE  = 3;
	localparam int         CRS_ST_DROP    = 4;
	// Descriptor layout
	localparam int         CRS_DESC_DW    = 3;
	localparam int         CRS_STAT_DW    = 1;
	localparam int         CRS_STAT_LSB   = 11;
	localparam int         CRS_STAT_W     = 3;
	localparam logic [2:0] CRS_CS_SC      = 3'h0;
	localparam logic [2:0] CRS_CS_UR      = 3'h1;
	localparam logic [2:0] CRS_CS_CA      = 3'h4;
	// Error packet request information
	localparam int         CRS_LOG_WORDS  = 5;
	localparam int         CRS_LOG_FIRST  = 3;
	// Sideband field
	localparam int         CRS_SB_DISC    = 0;
	// AXI4-Lite answers
	localparam logic [1:0] CRS_RESP_OK    = 2'h0;
	localparam logic [1:0] CRS_RESP_ERR   = 2'h2;
endpackage

// ---- core/crs_log_if.sv ----
// Write and read path between the framer and its request log store
`timescale 1ns/1ps
interface crs_log_if #(parameter int N = 5);
	logic [N-1:0]    wr_en;
	logic [N*32-1:0] wr_data;
	logic [2:0]      rd_idx;
	logic [31:0]     rd_data;
	modport writer (output wr_en, output wr_data, output rd_idx, input rd_data);
	modport store  (input wr_en, input wr_data, input rd_idx, output rd_data);
endinterface

// ---- core/crs_log_store.sv ----
// Small store holding the request information of the last error completion
`timescale 1ns/1ps
module crs_log_store import crs_pkg::*; #(
	parameter int N = CRS_LOG_WORDS
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	crs_log_if.store  lg
);
	logic [31:0] mem_reg [N];

	// Each word written on its own enable, several per beat on wide ports
	always_ff @(posedge aclk) begin
		for (int k = 0; k < N; k++) begin
			if (!aresetn) begin
				mem_reg[k] <= 32'h0000_0000;
			end else if (lg.wr_en[k]) begin
				mem_reg[k] <= lg.wr_data[k*32 +: 32];
			end
		end
	end

	// Registered read; unknown index reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lg.rd_data <= 32'h0000_0000;
		end else if (int'(lg.rd_idx) < N) begin
			lg.rd_data <= mem_reg[lg.rd_idx];
		end else begin
			lg.rd_data <= 32'h0000_0000;
		end
	end
endmodule

// ---- core/crs_pkt_check.sv ----
// Packet tracking: mid-packet valid drop and abort, both sticky to packet end
`timescale 1ns/1ps
module crs_pkt_check (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic valid,
	input  wire logic ready,
	input  wire logic last,
	input  wire logic disc,
	output logic      in_pkt,
	output logic      drop,
	output logic      abort_pkt,
	output logic      null_beat
);
	logic acc;
	logic err_reg;
	logic abt_reg;
	logic in_pkt_reg;

	assign acc = valid && ready;
	assign in_pkt = in_pkt_reg;
	// Valid low between beats of a packet is an error
	assign drop = in_pkt_reg && !valid;
	// Abort only counts when the beat is really taken
	assign abort_pkt = abt_reg || (acc && disc);
	assign null_beat = err_reg || (acc && disc);

	// Packet boundaries follow accepted beats only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_pkt_reg <= 1'b0;
		end else if (acc) begin
			in_pkt_reg <= !last;
		end
	end

	// Error held until the last beat even if abort is released early
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_reg <= 1'b0;
			abt_reg <= 1'b0;
		end else if (acc && last) begin
			err_reg <= 1'b0;
			abt_reg <= 1'b0;
		end else begin
			err_reg <= err_reg || drop || (acc && disc);
			abt_reg <= abt_reg || (acc && disc);
		end
	end
endmodule

// ---- core/crs_framer.sv ----
// Completion return stream framer with AXI4-Lite control and request log
// Notes on behaviour
// - No per-byte valid on the port; requester discards invalid bytes.
// - Valid dropping mid-packet is an error; the completion is nullified.
// - Device may drop ready any cycle; partner then holds all signals.
// - Abort bit during payload makes the device nullify that completion.
// - Abort only with payload; error stays sticky until packet end.
// - Abort sampled only when valid and ready are both high.
// - Endpoint reports an aborted completion as uncorrectable internal error.
// - Device logs the five request-information Dwords of an error completion.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module crs_framer import crs_pkg::*; #(
	parameter int DATA_W = 64,
	parameter int SIDE_W = 33,
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axil_awaddr,
	input  wire logic              s_axil_awvalid,
	output logic                   s_axil_awready,
	input  wire logic [31:0]       s_axil_wdata,
	input  wire logic [3:0]        s_axil_wstrb,
	input  wire logic              s_axil_wvalid,
	output logic                   s_axil_wready,
	output logic [1:0]             s_axil_bresp,
	output logic                   s_axil_bvalid,
	input  wire logic              s_axil_bready,
	input  wire logic [ADDR_W-1:0] s_axil_araddr,
	input  wire logic              s_axil_arvalid,
	output logic                   s_axil_arready,
	output logic [31:0]            s_axil_rdata,
	output logic [1:0]             s_axil_rresp,
	output logic                   s_axil_rvalid,
	input  wire logic              s_axil_rready,
	input  wire logic              cpl_in_valid,
	output logic                   cpl_in_ready,
	input  wire logic [DATA_W-1:0] cpl_in_data,
	input  wire logic              cpl_in_last,
	input  wire logic [SIDE_W-1:0] cpl_in_sideband,
	output logic                   tlp_out_valid,
	input  wire logic              tlp_out_ready,
	output logic [DATA_W-1:0]      tlp_out_data,
	output logic                   tlp_out_last,
	output logic                   tlp_out_null,
	output logic                   aer_internal_err
);
	localparam int BEAT_DW = DATA_W / 32;
	localparam int DESC_BEATS = (CRS_DESC_DW + BEAT_DW - 1) / BEAT_DW;

	logic              acc;
	logic              in_pkt;
	logic              drop;
	logic              abort_pkt;
	logic              null_beat;
	logic              payload_now;
	logic [10:0]       dw_base_reg;
	logic [10:0]       lane_idx;
	logic [2:0]        st_reg;
	logic [2:0]        st_now;
	logic [CRS_LOG_WORDS-1:0]    log_en;
	logic [CRS_LOG_WORDS*32-1:0] log_dat;
	logic [2:0]        ctrl_reg;
	logic [4:1]        stat_reg;
	logic [31:0]       cplcnt_reg;
	logic [31:0]       nulcnt_reg;
	logic              out_valid_next;
	logic              do_wr;
	logic              ar_hs;
	logic              rd_wait_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [ADDR_W-1:0] araddr_reg;
	logic [ADDR_W-1:0] rd_sel;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic [4:0]        st_set;
	logic [4:0]        st_clr;

	crs_log_if #(.N(CRS_LOG_WORDS)) lg ();

	assign acc = cpl_in_valid && cpl_in_ready;

	crs_pkt_check u_check (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.valid     (cpl_in_valid),
		.ready     (cpl_in_ready),
		.last      (cpl_in_last),
		.disc      (cpl_in_sideband[CRS_SB_DISC]),
		.in_pkt    (in_pkt),
		.drop      (drop),
		.abort_pkt (abort_pkt),
		.null_beat (null_beat)
	);

	crs_log_store #(.N(CRS_LOG_WORDS)) u_log (
		.aclk    (aclk),
		.aresetn (aresetn),
		.lg      (lg)
	);

	// Running Dword index of the first lane; packed error packets use it too
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dw_base_reg <= 11'h000;
		end else if (acc) begin
			dw_base_reg <= cpl_in_last ? 11'h000 : dw_base_reg + 11'(BEAT_DW);
		end
	end

	// Status and request-information Dwords picked out lane by lane
	always_comb begin
		lane_idx = 11'h000;
		st_now = st_reg;
		log_en = '0;
		log_dat = '0;
		for (int i = 0; i < BEAT_DW; i++) begin
			lane_idx = dw_base_reg + 11'(i);
			if (lane_idx == 11'(CRS_STAT_DW)) begin
				st_now = cpl_in_data[i*32+CRS_STAT_LSB +: CRS_STAT_W];
			end
			for (int k = 0; k < CRS_LOG_WORDS; k++) begin
				if (lane_idx == 11'(k + CRS_LOG_FIRST)) begin
					log_en[k] = acc;
					log_dat[k*32 +: 32] = cpl_in_data[i*32 +: 32];
				end
			end
		end
	end

	// Any packet whose status is not SC, be it UR, CA or another code, has its request information kept
	assign lg.wr_en = (st_now != CRS_CS_SC) ? log_en : '0;
	assign lg.wr_data = log_dat;

	// Completion status of the packet in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= CRS_CS_SC;
		end else if (acc) begin
			st_reg <= cpl_in_last ? CRS_CS_SC : st_now;
		end
	end

	// Payload beats differ by mode: packed, or from the beat after the descriptor
	assign payload_now = ctrl_reg[CRS_CTRL_ADDR] ? (dw_base_reg >= 11'(DESC_BEATS * BEAT_DW))
	                                             : (dw_base_reg + 11'(BEAT_DW) > 11'(CRS_DESC_DW));

	// Output beat register; data pass untouched, no byte enables exist
	assign out_valid_next = acc ? 1'b1 : (tlp_out_valid && tlp_out_ready) ? 1'b0 : tlp_out_valid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tlp_out_valid <= 1'b0;
			tlp_out_data  <= '0;
			tlp_out_last  <= 1'b0;
			tlp_out_null  <= 1'b0;
		end else begin
			tlp_out_valid <= out_valid_next;
			if (acc) begin
				tlp_out_data <= cpl_in_data;
				tlp_out_last <= cpl_in_last;
				tlp_out_null <= null_beat && cpl_in_last;
			end
		end
	end

	// Ready from a flop: one beat in flight halves throughput but needs no skid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpl_in_ready <= 1'b0;
		end else begin
			cpl_in_ready <= ctrl_reg[CRS_CTRL_EN] && !out_valid_next;
		end
	end

	// Aborted completion reported once, at its last beat, in endpoint role
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aer_internal_err <= 1'b0;
		end else begin
			aer_internal_err <= acc && cpl_in_last && abort_pkt && ctrl_reg[CRS_CTRL_EP];
		end
	end

	// Completion and nullified-completion counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cplcnt_reg <= 32'h0000_0000;
			nulcnt_reg <= 32'h0000_0000;
		end else if (acc && cpl_in_last) begin
			cplcnt_reg <= cplcnt_reg + 32'h0000_0001;
			nulcnt_reg <= nulcnt_reg + (null_beat ? 32'h0000_0001 : 32'h0000_0000);
		end
	end

	// Sticky status, hardware set wins over a software clear
	always_comb begin
		st_set = '0;
		st_set[CRS_ST_LOGV] = acc && cpl_in_last && (st_now != CRS_CS_SC);
		st_set[CRS_ST_ABORT] = acc && cpl_in_sideband[CRS_SB_DISC];
		st_set[CRS_ST_MISUSE] = acc && cpl_in_sideband[CRS_SB_DISC] && (!payload_now || st_now != CRS_CS_SC);
		st_set[CRS_ST_DROP] = drop;
		st_clr = (do_wr && awaddr_reg == CRS_STAT_OFS && wstrb_reg[0]) ? wdata_reg[4:0] : '0;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= (stat_reg & ~st_clr[4:1]) | st_set[4:1];
		end
	end

	// Write channels taken in either order, performed once both are held
	assign do_wr = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_awready <= 1'b1;
			s_axil_wready  <= 1'b1;
			s_axil_bvalid  <= 1'b0;
			s_axil_bresp   <= CRS_RESP_OK;
			awaddr_reg     <= '0;
			wdata_reg      <= 32'h0000_0000;
			wstrb_reg      <= 4'h0;
		end else begin
			if (s_axil_awvalid && s_axil_awready) begin
				s_axil_awready <= 1'b0;
				awaddr_reg     <= s_axil_awaddr;
			end
			if (s_axil_wvalid && s_axil_wready) begin
				s_axil_wready <= 1'b0;
				wdata_reg     <= s_axil_wdata;
				wstrb_reg     <= s_axil_wstrb;
			end
			if (do_wr) begin
				s_axil_bvalid <= 1'b1;
				s_axil_bresp  <= (awaddr_reg == CRS_CTRL_OFS || awaddr_reg == CRS_STAT_OFS) ? CRS_RESP_OK
				                                                                          : CRS_RESP_ERR;
			end else if (s_axil_bvalid && s_axil_bready) begin
				s_axil_bvalid  <= 1'b0;
				s_axil_awready <= 1'b1;
				s_axil_wready  <= 1'b1;
			end
		end
	end

	// Control register; only byte lane 0 holds bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CRS_CTRL_RST;
		end else if (do_wr && awaddr_reg == CRS_CTRL_OFS && wstrb_reg[0]) begin
			ctrl_reg <= wdata_reg[2:0];
		end
	end

	// Log index steered from the incoming address so its read lands in time
	assign ar_hs = s_axil_arvalid && s_axil_arready;
	assign rd_sel = ar_hs ? s_axil_araddr : araddr_reg;
	assign lg.rd_idx = 3'((rd_sel - CRS_LOG0_OFS) >> 2);

	// Read answers one edge after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_arready <= 1'b1;
			s_axil_rvalid  <= 1'b0;
			s_axil_rdata   <= 32'h0000_0000;
			s_axil_rresp   <= CRS_RESP_OK;
			rd_wait_reg    <= 1'b0;
			araddr_reg     <= '0;
		end else if (ar_hs) begin
			s_axil_arready <= 1'b0;
			araddr_reg     <= s_axil_araddr;
			rd_wait_reg    <= 1'b1;
		end else if (rd_wait_reg) begin
			rd_wait_reg   <= 1'b0;
			s_axil_rvalid <= 1'b1;
			s_axil_rresp  <= CRS_RESP_OK;
			unique case (araddr_reg)
				CRS_CTRL_OFS:   s_axil_rdata <= {29'h0, ctrl_reg};
				CRS_STAT_OFS:   s_axil_rdata <= {27'h0, stat_reg, in_pkt};
				CRS_CPLCNT_OFS: s_axil_rdata <= cplcnt_reg;
				CRS_NULCNT_OFS: s_axil_rdata <= nulcnt_reg;
				default: begin
					if (araddr_reg >= CRS_LOG0_OFS && araddr_reg <= CRS_LOG4_OFS && araddr_reg[1:0] == 2'h0) begin
						s_axil_rdata <= lg.rd_data;
					end else begin
						s_axil_rdata <= 32'h0000_0000;
						s_axil_rresp <= CRS_RESP_ERR;
					end
				end
			endcase
		end else if (s_axil_rvalid && s_axil_rready) begin
			s_axil_rvalid  <= 1'b0;
			s_axil_arready <= 1'b1;
		end
	end

	// Checks on the completion path
	drop_null_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_pkt && !cpl_in_valid) |=> null_beat)
		else $error("valid drop did not nullify");
	null_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(acc && cpl_in_last && null_beat) |=> (tlp_out_valid && tlp_out_last && tlp_out_null))
		else $error("marked completion not nullified");
	disc_null_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(acc && cpl_in_last && cpl_in_sideband[CRS_SB_DISC]) |=> (tlp_out_valid && tlp_out_last && tlp_out_null))
		else $error("aborted completion not nullified");
	sticky_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(acc && !cpl_in_last && cpl_in_sideband[CRS_SB_DISC]) |=> null_beat)
		else $error("abort not sticky");
	sticky_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_pkt && null_beat && !(acc && cpl_in_last)) |=> null_beat)
		else $error("abort released before packet end");
	abort_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cpl_in_valid && !cpl_in_ready && cpl_in_sideband[CRS_SB_DISC] && !abort_pkt) |=> (!abort_pkt || acc))
		else $error("abort sampled without handshake");
	ready_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tlp_out_valid && !tlp_out_ready) |-> !cpl_in_ready)
		else $error("ready high while output stalled");
	data_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
		acc |=> (tlp_out_valid && tlp_out_data == $past(cpl_in_data) && tlp_out_last == $past(cpl_in_last)))
		else $error("beat not passed intact");
	out_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tlp_out_valid && !tlp_out_ready) |=> (tlp_out_valid && $stable(tlp_out_data) && $stable(tlp_out_last)))
		else $error("output changed while stalled");
	aer_report_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(acc && cpl_in_last && cpl_in_sideband[CRS_SB_DISC] && ctrl_reg[CRS_CTRL_EP]) |=> aer_internal_err ##1 !aer_internal_err)
		else $error("aborted completion not reported");
	log_valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(acc && cpl_in_last && st_now != CRS_CS_SC) |=> stat_reg[CRS_ST_LOGV])
		else $error("error completion not logged");
endmodule

// ---- tb/crs_cpl_source.sv ----
// Model of the user logic returning completion packets on the stream port
`timescale 1ns/1ps
module crs_cpl_source (
	input  wire logic   aclk,
	input  wire logic   cpl_in_ready,
	output logic        cpl_in_valid,
	output logic [63:0] cpl_in_data,
	output logic        cpl_in_last,
	output logic [32:0] cpl_in_sideband,
	output logic        hung
);
	// Port idle and quiet from time zero
	initial begin
		cpl_in_valid = 1'b0;
		cpl_in_data = 64'h0;
		cpl_in_last = 1'b0;
		cpl_in_sideband = 33'h0;
		hung = 1'b0;
	end

	// One packet of n Dwords; ab = beat carrying abort, dr = beat preceded by a valid gap
	task automatic send(input logic [31:0] w[16], input int n, input int ab, input int dr);
		int nb;
		int g;
		nb = (n + 1) / 2;
		@(posedge aclk);
		for (int b = 0; b < nb; b++) begin
			if (b == dr) begin
				// Deliberate one-cycle gap inside the packet
				cpl_in_valid <= 1'b0;
				cpl_in_data <= ~cpl_in_data;
				@(posedge aclk);
			end
			cpl_in_valid <= 1'b1;
			cpl_in_data <= {(2 * b + 1 < n) ? w[2 * b + 1] : 32'h0, w[2 * b]};
			cpl_in_last <= (b == nb - 1);
			cpl_in_sideband <= {32'h0, b == ab};
			g = 0;
			// Held unchanged until ready is sampled high
			do begin
				@(posedge aclk);
				g++;
			end while (cpl_in_ready !== 1'b1 && g < 500);
			if (g >= 500) hung <= 1'b1;
		end
		// Released data shows the inverse so a stale beat is never mistaken for a fresh one
		cpl_in_valid <= 1'b0;
		cpl_in_last <= 1'b0;
		cpl_in_sideband <= 33'h0;
		cpl_in_data <= ~cpl_in_data;
	endtask
endmodule

// ---- tb/crs_framer_tb.sv ----
// Self-checking bench for the completion return stream framer
`timescale 1ns/1ps
module crs_framer_tb import crs_pkg::*;;
	logic        aclk, aresetn, src_hung, stall;
	logic [7:0]  s_axil_awaddr, s_axil_araddr;
	logic [31:0] s_axil_wdata, s_axil_rdata;
	logic [3:0]  s_axil_wstrb;
	logic [1:0]  s_axil_bresp, s_axil_rresp;
	logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid, s_axil_bready;
	logic        s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
	logic        cpl_in_valid, cpl_in_ready, cpl_in_last;
	logic [63:0] cpl_in_data, tlp_out_data;
	logic [32:0] cpl_in_sideband;
	logic        tlp_out_valid, tlp_out_ready, tlp_out_last, tlp_out_null, aer_internal_err;
	logic [31:0] w[16];
	logic [63:0] oq[$];
	logic        ol[$];
	logic        on[$];
	int          fail_count, comparisons, aer_n, cyc;

	crs_framer DUT (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
		.s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
		.s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
		.s_axil_rready, .cpl_in_valid, .cpl_in_ready, .cpl_in_data, .cpl_in_last, .cpl_in_sideband,
		.tlp_out_valid, .tlp_out_ready, .tlp_out_data, .tlp_out_last, .tlp_out_null, .aer_internal_err);

	crs_cpl_source P (.aclk, .cpl_in_ready, .cpl_in_valid, .cpl_in_data, .cpl_in_last, .cpl_in_sideband,
		.hung(src_hung));

	// 20 MHz clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Link side: takes beats, stalling two cycles in three when asked
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		tlp_out_ready <= !stall || (cyc % 3 == 0);
		if (tlp_out_valid === 1'b1 && tlp_out_ready === 1'b1) begin
			oq.push_back(tlp_out_data);
			ol.push_back(tlp_out_last);
			on.push_back(tlp_out_null);
		end
		if (aer_internal_err === 1'b1) aer_n++;
		if (src_hung === 1'b1) begin
			fail_count++;
			test_done();
		end
	end

	task test_done;
		if (fail_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// A wait that ran out of its bound ends the run
	task guard(input int g);
		if (g >= 200) begin
			fail_count++;
			test_done();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int g;
		logic aw;
		logic wd;
		aw = 1'b0;
		wd = 1'b0;
		g = 0;
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_awvalid <= 1'b1;
		s_axil_wdata <= d;
		s_axil_wstrb <= 4'hF;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		while (!(aw && wd) && g < 200) begin
			@(posedge aclk);
			g++;
			if (!aw && s_axil_awready === 1'b1) begin
				aw = 1'b1;
				s_axil_awvalid <= 1'b0;
			end
			if (!wd && s_axil_wready === 1'b1) begin
				wd = 1'b1;
				s_axil_wvalid <= 1'b0;
			end
		end
		guard(g);
		g = 0;
		do begin
			@(posedge aclk);
			g++;
		end while (s_axil_bvalid !== 1'b1 && g < 200);
		guard(g);
		chk("write response", er, s_axil_bresp);
		s_axil_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int g;
		g = 0;
		@(posedge aclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do begin
			@(posedge aclk);
			g++;
		end while (s_axil_arready !== 1'b1 && g < 200);
		s_axil_arvalid <= 1'b0;
		while (s_axil_rvalid !== 1'b1 && g < 200) begin
			@(posedge aclk);
			g++;
		end
		guard(g);
		chk("read data", ed, s_axil_rdata);
		chk("read response", er, s_axil_rresp);
		s_axil_rready <= 1'b0;
	endtask

	// Completion words: low address start Dword 1, status, Dword count, request info
	task automatic mk(input logic [2:0] st, input int n);
		for (int i = 0; i < 16; i++) w[i] = {16'hBEE0, 16'(i)};
		w[0] = 32'h0000_0004;
		w[1] = {18'h0, st, (st == CRS_CS_SC) ? 11'(n - 3) : 11'h0};
		if (st != CRS_CS_SC) w[3] = {13'h0, 1'b1, 2'h2, 8'h5A, 4'hC, 4'h3};
	endtask

	// Send one packet and compare every beat seen on the link side
	task automatic pkt(input int n, input int ab, input int dr, input logic en);
		int nb;
		int g;
		nb = (n + 1) / 2;
		g = 0;
		oq.delete();
		ol.delete();
		on.delete();
		P.send(w, n, ab, dr);
		while (oq.size() < nb && g < 200) begin
			@(posedge aclk);
			g++;
		end
		guard(g);
		for (int b = 0; b < nb; b++) begin
			chk("out data", {(2 * b + 1 < n) ? w[2 * b + 1] : 32'h0, w[2 * b]}, oq[b]);
			chk("out last", b == nb - 1, ol[b]);
			chk("out null", (b == nb - 1) && en, on[b]);
		end
	endtask

	task automatic s_regs;
		rd(CRS_CTRL_OFS, 32'(CRS_CTRL_RST), CRS_RESP_OK);
		rd(CRS_STAT_OFS, 32'h0, CRS_RESP_OK);
		rd(CRS_CPLCNT_OFS, 32'h0, CRS_RESP_OK);
		rd(CRS_NULCNT_OFS, 32'h0, CRS_RESP_OK);
		rd(8'h40, 32'h0, CRS_RESP_ERR);
		wr(8'h40, 32'hFFFF_FFFF, CRS_RESP_ERR);
	endtask

	// Clean completions, Dword-aligned then address-aligned with lane offset
	task automatic s_sc;
		stall = 1'b1;
		for (int m = 0; m < 2; m++) begin
			wr(CRS_CTRL_OFS, 32'h0000_0005 | 32'(m << 1), CRS_RESP_OK);
			rd(CRS_CTRL_OFS, 32'h0000_0005 | 32'(m << 1), CRS_RESP_OK);
			mk(CRS_CS_SC, m ? 9 : 7);
			if (m == 1) begin
				w[1][10:0] = 11'h4;
				w[3] = 32'h0;
				w[4] = 32'h0;
			end
			pkt(m ? 9 : 7, -1, -1, 1'b0);
			rd(CRS_CPLCNT_OFS, 32'(m + 1), CRS_RESP_OK);
		end
		stall = 1'b0;
		wr(CRS_CTRL_OFS, 32'h0000_0005, CRS_RESP_OK);
	endtask

	// Abort mid-payload carried on, then abort on the closing beat
	task automatic s_abort;
		int a0;
		a0 = aer_n;
		mk(CRS_CS_SC, 9);
		pkt(9, 2, -1, 1'b1);
		chk("aer pulses", a0 + 1, aer_n);
		mk(CRS_CS_SC, 6);
		pkt(6, 2, -1, 1'b1);
		chk("aer pulses", a0 + 2, aer_n);
		rd(CRS_STAT_OFS, 32'h0000_0004, CRS_RESP_OK);
		rd(CRS_NULCNT_OFS, 32'h2, CRS_RESP_OK);
		wr(CRS_STAT_OFS, 32'h0000_001E, CRS_RESP_OK);
		rd(CRS_STAT_OFS, 32'h0, CRS_RESP_OK);
	endtask

	task automatic s_drop;
		mk(CRS_CS_SC, 7);
		pkt(7, -1, 2, 1'b1);
		rd(CRS_STAT_OFS, 32'h0000_0010, CRS_RESP_OK);
		rd(CRS_NULCNT_OFS, 32'h3, CRS_RESP_OK);
		wr(CRS_STAT_OFS, 32'h0000_001E, CRS_RESP_OK);
	endtask

	// Unsupported request and completer abort packets feed the request log
	task automatic s_err;
		for (int c = 0; c < 2; c++) begin
			mk(c ? CRS_CS_CA : CRS_CS_UR, 8);
			w[4] = w[4] + 32'(c);
			pkt(8, -1, -1, 1'b0);
			for (int i = 0; i < 5; i++) rd(8'(CRS_LOG0_OFS + 4 * i), w[3 + i], CRS_RESP_OK);
			rd(CRS_STAT_OFS, 32'h0000_0002, CRS_RESP_OK);
		end
	endtask

	// Abort with endpoint off, then port disabled
	task automatic s_ctrl;
		int a0;
		wr(CRS_CTRL_OFS, 32'h0000_0001, CRS_RESP_OK);
		a0 = aer_n;
		mk(CRS_CS_SC, 7);
		pkt(7, 3, -1, 1'b1);
		chk("aer pulses", a0, aer_n);
		rd(CRS_STAT_OFS, 32'h0000_0006, CRS_RESP_OK);
		// Abort on a descriptor beat in address-aligned mode counts as misuse
		wr(CRS_CTRL_OFS, 32'h0000_0003, CRS_RESP_OK);
		mk(CRS_CS_SC, 7);
		pkt(7, 1, -1, 1'b1);
		chk("aer pulses", a0, aer_n);
		rd(CRS_STAT_OFS, 32'h0000_000E, CRS_RESP_OK);
		wr(CRS_CTRL_OFS, 32'h0, CRS_RESP_OK);
		@(posedge aclk);
		repeat (10) begin
			@(posedge aclk);
			chk("ready while disabled", 1'b0, cpl_in_ready);
		end
		wr(CRS_CTRL_OFS, 32'h0000_0005, CRS_RESP_OK);
	endtask

	// Hang cut-off
	initial begin
		repeat (50000) @(posedge aclk);
		fail_count++;
		test_done();
	end

	initial begin
		{aresetn, stall, tlp_out_ready, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = 6'h0;
		{s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr} = 18'h0;
		s_axil_wdata = 32'h0;
		s_axil_wstrb = 4'h0;
		{fail_count, comparisons, aer_n, cyc} = {4{32'h0}};
		repeat (20) @(posedge aclk);
		chk("ready in reset", 1'b0, cpl_in_ready);
		aresetn <= 1'b1;
		s_regs();
		s_sc();
		s_abort();
		s_drop();
		s_err();
		s_ctrl();
		test_done();
	end
endmodule
